// file: src/tcgpo_i2c_slave.v
// i2c slave register port with host-driven general outputs
`timescale 1ns/1ps
`include "tcgpo_defines.vh"
module tcgpo_i2c_slave #(
  parameter NREG          = 8,
  parameter AW            = 3,
  parameter BOOT_NORM_CYC = `TC_BOOT_NORM_MS * `TC_CLK_KHZ,
  parameter BOOT_HIGH_CYC = `TC_BOOT_HIGH_MS * `TC_CLK_KHZ,
  parameter GAP_CYC       = `TC_GAP_MS * `TC_CLK_KHZ,
  parameter PULSE_CYC     = `TC_PULSE_MS * `TC_CLK_KHZ
) (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut_r,
  output reg        sdaOeN_r,
  input  wire       attnIn,
  output reg        attnOut_r,
  output reg        attnOeN_r,
  input  wire       attnReq,
  input  wire [6:0] slaveAddr,
  input  wire       noiseHigh,
  input  wire [2:0] devMode,
  input  wire [1:0] beeperCfg,
  input  wire       beeperWaveA,
  input  wire       beeperWaveB,
  output reg        hostOutA_r,
  output reg        hostOutB_r,
  output reg        beeperPinA_r,
  output reg        beeperPinB_r,
  output reg        bootDone_r
);
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_ADDR   = 4'h1;
  localparam [3:0] ST_REG    = 4'h2;
  localparam [3:0] ST_WDAT   = 4'h3;
  localparam [3:0] ST_RDAT   = 4'h4;
  localparam [3:0] ST_IGN    = 4'h5;
  localparam [3:0] ST_COMMIT = 4'h6;
  localparam [26:0] BOOT_N   = BOOT_NORM_CYC;
  localparam [26:0] BOOT_H   = BOOT_HIGH_CYC;
  localparam [26:0] PULSE_N  = PULSE_CYC;
  localparam [26:0] GAP_N    = GAP_CYC;
  localparam [5:0]  WMAX     = `TC_MAX_WBYTES;

  wire       sclS;
  wire       sdaS;
  wire       attnS;
  reg        sclD_r;
  reg        sdaD_r;
  reg  [3:0] state_r;
  reg  [3:0] bitCnt_r;
  reg        ackPh_r;
  reg        acked_r;
  reg        mAck_r;
  reg        rdWr_r;
  reg  [7:0] rxSh_r;
  reg  [7:0] txSh_r;
  reg  [7:0] ptr_r;
  reg  [AW-1:0] rdPtr_r;
  reg  [5:0] wrCnt_r;
  reg  [5:0] cmIdx_r;
  reg  [26:0] upCnt_r;
  reg  [26:0] gapCnt_r;
  reg  [7:0] regs [0:NREG-1];
  reg  [7:0] snap [0:NREG-1];
  reg  [7:0] wrBuf [0:`TC_MAX_WBYTES-1];
  integer    i;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tcgpo_sync u_syncScl (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (sclIn),
    .dout    (sclS)
  );
  tcgpo_sync u_syncSda (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (sdaIn),
    .dout    (sdaS)
  );
  tcgpo_sync u_syncAttn (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (attnIn),
    .dout    (attnS)
  );

  // ----------------------------------------------------------------
  // bus event decode
  // ----------------------------------------------------------------
  wire sclRise  = sclS & ~sclD_r;
  wire sclFall  = ~sclS & sclD_r;
  wire busStart = sclS & sclD_r & sdaD_r & ~sdaS;
  wire busStop  = sclS & sclD_r & ~sdaD_r & sdaS;
  wire [7:0] rxByte = rxSh_r;
  wire gapDone  = (gapCnt_r == 27'h0000000);
  wire modeOk   = (devMode == `TC_MODE_OPER) | (devMode == `TC_MODE_PLT) |
                  (devMode == `TC_MODE_DEBUG);
  wire bootOk   = noiseHigh ? (upCnt_r >= BOOT_H) : (upCnt_r >= BOOT_N);
  wire addrHit  = (rxByte[7:1] == slaveAddr) & bootOk & ~attnS;
  wire [AW-1:0] cmReg = ptr_r[AW-1:0] + cmIdx_r[AW-1:0];
  wire [7:0] statByte = {bootOk, noiseHigh, beeperCfg, 1'b0, devMode};

  // ----------------------------------------------------------------
  // edge history of synchronised lines
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  // ----------------------------------------------------------------
  // power-on timer: boot nack window and output pulse
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      upCnt_r    <= 27'h0000000;
      bootDone_r <= 1'b0;
    end else begin
      if (upCnt_r != 27'h7ffffff)
        upCnt_r <= upCnt_r + 27'h0000001;
      bootDone_r <= bootOk;
    end
  end

  // ----------------------------------------------------------------
  // output pins, attention line, constant data-pin level
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hostOutA_r   <= 1'b0;
      hostOutB_r   <= 1'b0;
      beeperPinA_r <= 1'b0;
      beeperPinB_r <= 1'b0;
      sdaOut_r     <= 1'b0;
      attnOut_r    <= 1'b0;
      attnOeN_r    <= 1'b1;
    end else begin
      hostOutA_r   <= regs[`TC_REG_GPO][0];
      hostOutB_r   <= (upCnt_r < PULSE_N) | regs[`TC_REG_GPO][1];
      // beeper pins fall back to host outputs when the beeper is off
      beeperPinA_r <= (beeperCfg == `TC_BEEP_NONE) ? regs[`TC_REG_GPO][3] :
                      beeperWaveA;
      beeperPinB_r <= (beeperCfg == `TC_BEEP_TWO) ? beeperWaveB :
                      regs[`TC_REG_GPO][2];
      sdaOut_r     <= 1'b0;
      attnOut_r    <= 1'b0;
      attnOeN_r    <= ~attnReq;
    end
  end

  // ----------------------------------------------------------------
  // transaction engine, register file and spacing timer
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 4'h0;
      ackPh_r  <= 1'b0;
      acked_r  <= 1'b0;
      mAck_r   <= 1'b0;
      rdWr_r   <= 1'b0;
      rxSh_r   <= 8'h00;
      txSh_r   <= 8'hff;
      ptr_r    <= 8'h00;
      rdPtr_r  <= {AW{1'b0}};
      wrCnt_r  <= 6'h00;
      cmIdx_r  <= 6'h00;
      gapCnt_r <= 27'h0000000;
      sdaOeN_r <= 1'b1;
      for (i = 0; i < NREG; i = i + 1) begin
        regs[i] <= 8'h00;
        snap[i] <= 8'h00;
      end
      for (i = 0; i < `TC_MAX_WBYTES; i = i + 1)
        wrBuf[i] <= 8'h00;
    end else begin
      if (!gapDone)
        gapCnt_r <= gapCnt_r - 27'h0000001;
      regs[`TC_REG_STAT] <= statByte;
      if (state_r == ST_COMMIT) begin
        // one buffered byte per cycle; later bytes to one index win
        if (cmReg != `TC_REG_STAT &&
            (cmReg != `TC_REG_GPO || modeOk))
          regs[cmReg] <= wrBuf[cmIdx_r[4:0]];
        if (cmIdx_r + 6'h01 >= wrCnt_r)
          state_r <= ST_IDLE;
        cmIdx_r <= cmIdx_r + 6'h01;
      end else if (busStart) begin
        // a start outside ST_COMMIT begins a fresh frame; pending write data dropped
        state_r  <= ST_ADDR;
        bitCnt_r <= 4'h0;
        ackPh_r  <= 1'b0;
        acked_r  <= 1'b0;
        wrCnt_r  <= 6'h00;
        sdaOeN_r <= 1'b1;
      end else if (busStop) begin
        sdaOeN_r <= 1'b1;
        ackPh_r  <= 1'b0;
        if (acked_r)
          gapCnt_r <= GAP_N;
        if ((state_r == ST_WDAT) && (wrCnt_r != 6'h00)) begin
          state_r <= ST_COMMIT;
          cmIdx_r <= 6'h00;
        end else begin
          state_r <= ST_IDLE;
        end
      end else begin
        case (state_r)
          ST_ADDR, ST_REG, ST_WDAT: begin
            if (sclRise && !ackPh_r) begin
              rxSh_r   <= {rxSh_r[6:0], sdaS};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && !ackPh_r && bitCnt_r == 4'h8) begin
              ackPh_r  <= 1'b1;
              bitCnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (addrHit) begin
                  sdaOeN_r <= 1'b0;
                  acked_r  <= 1'b1;
                  rdWr_r   <= rxByte[0];
                  rdPtr_r  <= ptr_r[AW-1:0];
                  // a read too soon after the last frame repeats old data
                  if (rxByte[0] && gapDone) begin
                    for (i = 0; i < NREG; i = i + 1)
                      snap[i] <= regs[i];
                  end
                end else begin
                  sdaOeN_r <= 1'b1;
                  state_r  <= ST_IGN;
                end
              end else if (state_r == ST_REG) begin
                ptr_r    <= rxByte;
                sdaOeN_r <= 1'b0;
              end else if (wrCnt_r < WMAX) begin
                wrBuf[wrCnt_r[4:0]] <= rxByte;
                wrCnt_r  <= wrCnt_r + 6'h01;
                sdaOeN_r <= 1'b0;
              end else begin
                sdaOeN_r <= 1'b1;
                state_r  <= ST_IGN;
              end
            end else if (sclFall && ackPh_r) begin
              // end of our ack bit: release or start sending
              ackPh_r <= 1'b0;
              if (state_r == ST_ADDR && rdWr_r) begin
                state_r  <= ST_RDAT;
                txSh_r   <= snap[rdPtr_r];
                sdaOeN_r <= snap[rdPtr_r][7];
              end else begin
                sdaOeN_r <= 1'b1;
                if (state_r == ST_ADDR)
                  state_r <= ST_REG;
                else
                  state_r <= ST_WDAT;
              end
            end
          end
          ST_RDAT: begin
            if (sclRise) begin
              if (ackPh_r)
                mAck_r <= ~sdaS;
              else
                bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall) begin
              if (ackPh_r) begin
                ackPh_r <= 1'b0;
                if (mAck_r) begin
                  rdPtr_r  <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
                  txSh_r   <= snap[rdPtr_r + {{(AW-1){1'b0}}, 1'b1}];
                  sdaOeN_r <= snap[rdPtr_r + {{(AW-1){1'b0}}, 1'b1}][7];
                end else begin
                  sdaOeN_r <= 1'b1;
                  state_r  <= ST_IGN;
                end
              end else if (bitCnt_r == 4'h8) begin
                // release the line for the master's ack bit
                sdaOeN_r <= 1'b1;
                ackPh_r  <= 1'b1;
                bitCnt_r <= 4'h0;
              end else begin
                txSh_r   <= {txSh_r[6:0], 1'b1};
                sdaOeN_r <= txSh_r[6];
              end
            end
          end
          ST_IGN: begin
            sdaOeN_r <= 1'b1;
          end
          ST_IDLE: begin
            sdaOeN_r <= 1'b1;
          end
          default: begin
            state_r  <= ST_IDLE;
            sdaOeN_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // scl is input only, so the clock is never stretched
  // bit timing follows the master at any rate the sampling allows
  // a frame is expected only with the attention line low
endmodule

// file: src/tcgpo_defines.vh
// constants for the touch controller i2c slave and host-driven outputs
// Summary of operation
// - two dedicated host-written output pins
// - beeper pins become outputs when unused
// - output writes accepted in three modes only
// - first output low after reset, second high until its pulse ends, push-pull drive
// - output levels volatile, host rewrites after reset
// - second output pulses high 16 ms at power-on
// - i2c slave up to 100 kbps
// - hardware 7-bit address compare, default 37h
// - never holds scl low
// - at most 32 data bytes per write
// - attention line low before any transaction
// - nack everything 350/1000 ms after power-on
// - 60 ms spacing, early read repeats data
// - same-register rewrite inside 60 ms overwrites
// - write: address, register, data, auto-increment
// - address-only write loads read pointer
// - read returns pointer byte then successive bytes
// - address mismatch ignored until next start
// - nack allowed while attention line high
// - attention line active-low open-drain, both drive
`ifndef TCGPO_DEFINES_VH
`define TCGPO_DEFINES_VH

// ----------------------------------------------------------------
// timing, write limit and default address
// ----------------------------------------------------------------
`define TC_CLK_KHZ        100000
`define TC_BOOT_NORM_MS   350
`define TC_BOOT_HIGH_MS   1000
`define TC_GAP_MS         60
`define TC_PULSE_MS       16
`define TC_MAX_WBYTES     32
`define TC_DEF_ADDR       7'h37

// ----------------------------------------------------------------
// register map (byte index)
// ----------------------------------------------------------------
`define TC_REG_GPO        3'h0
`define TC_REG_STAT       3'h1

// ----------------------------------------------------------------
// device modes and beeper configurations
// ----------------------------------------------------------------
`define TC_MODE_OPER      3'h0
`define TC_MODE_LEDCFG    3'h1
`define TC_MODE_DEVCFG    3'h2
`define TC_MODE_PLT       3'h3
`define TC_MODE_DEBUG     3'h4
`define TC_BEEP_NONE      2'h0
`define TC_BEEP_ONE       2'h1
`define TC_BEEP_TWO       2'h2

`endif

// file: src/tcgpo_sync.v
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module tcgpo_sync (
  input  wire clk_sys,
  input  wire reset,
  input  wire din,
  output wire dout
);
  reg stage1_r;
  reg stage2_r;

  // ----------------------------------------------------------------
  // two flops, idle bus level high
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1_r <= 1'b1;
      stage2_r <= 1'b1;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule

// file: test/tcgpo_checker.sv
// assertion checker for the i2c slave and host-driven outputs
`timescale 1ns/1ps
module tcgpo_checker #(
  parameter PULSE_CYC     = 300,
  parameter BOOT_NORM_CYC = 2000,
  parameter BOOT_HIGH_CYC = 4000
) (
  input wire       clk_sys,
  input wire       reset,
  input wire       sclIn,
  input wire       sdaIn,
  input wire       sdaOut_r,
  input wire       sdaOeN_r,
  input wire       attnOut_r,
  input wire       attnOeN_r,
  input wire       attnReq,
  input wire       noiseHigh,
  input wire [1:0] beeperCfg,
  input wire       beeperWaveA,
  input wire       beeperWaveB,
  input wire       hostOutA_r,
  input wire       hostOutB_r,
  input wire       beeperPinA_r,
  input wire       beeperPinB_r,
  input wire       bootDone_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [31:0] cyc;
  // cycles since reset release, saturating
  always @(posedge clk_sys or posedge reset)
    if (reset) cyc <= 32'h0;
    else if (cyc != 32'hffffffff) cyc <= cyc + 32'h1;
  a_pins_open_drain: assert property (sdaOut_r == 1'b0 && attnOut_r == 1'b0)
    else $error("drive value not low");
  a_attn_on_request: assert property (attnReq |=> !attnOeN_r)
    else $error("attention not pulled");
  a_pulse_high: assert property ((cyc >= 32'd2 && cyc < PULSE_CYC) |-> hostOutB_r)
    else $error("power-on pulse missing");
  a_pulse_ends: assert property ((cyc > PULSE_CYC + 2 && !bootDone_r) |-> !hostOutB_r)
    else $error("power-on pulse too long");
  a_boot_early: assert property ((cyc < (noiseHigh ? BOOT_HIGH_CYC : BOOT_NORM_CYC) - 1) |-> !bootDone_r)
    else $error("boot window too short");
  a_boot_late: assert property ((cyc > BOOT_HIGH_CYC + 8) |-> bootDone_r)
    else $error("boot window never ends");
  a_boot_no_ack: assert property (!bootDone_r |-> sdaOeN_r)
    else $error("data line pulled during boot");
  a_beeper_a_wave: assert property ((beeperCfg != 2'h0 && $stable(beeperCfg)) |=> beeperPinA_r == $past(beeperWaveA))
    else $error("beeper pin a not wave");
  a_beeper_b_wave: assert property ((beeperCfg == 2'h2 && $stable(beeperCfg)) |=> beeperPinB_r == $past(beeperWaveB))
    else $error("beeper pin b not wave");
  a_output_holds: assert property ($changed(hostOutA_r) |-> sclIn && sdaIn)
    else $error("output changed inside frame");
  cover property ($fell(sdaOeN_r));
  cover property ($rose(hostOutA_r));
  cover property (beeperCfg == 2'h2 && beeperPinB_r);
endmodule
bind tcgpo_i2c_slave tcgpo_checker #(.PULSE_CYC(PULSE_CYC), .BOOT_NORM_CYC(BOOT_NORM_CYC),
  .BOOT_HIGH_CYC(BOOT_HIGH_CYC)) i_tcgpo_checker (.*);

// file: test/tcgpo_host_model.sv
// i2c master model standing in for the host processor
`timescale 1ns/1ps
module tcgpo_host_model (
  output logic scl,
  output logic sdaLow,
  input  wire  sda
);
  // bus idle: clock stands high, data released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // one bit, 200 ns: data moves 40 ns into the 120 ns low, sampled mid-high
  task automatic clockBit(input logic b, output logic r);
    scl = 1'b0;
    #40 sdaLow = !b;
    #80 scl = 1'b1;
    #40 r = sda;
    #40;
  endtask
  task automatic start;
    #80 sdaLow = 1'b1;
    #80;
  endtask
  // data rises while clock high, every frame ends here
  task automatic stop;
    scl = 1'b0;
    #40 sdaLow = 1'b1;
    #80 scl = 1'b1;
    #80 sdaLow = 1'b0;
    #80;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clockBit(d[i], r);
    clockBit(1'b1, r);
    ack = !r;
  endtask
  // last wanted byte gets a nack
  task automatic getByte(input logic ackIt, output logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i]);
    clockBit(!ackIt, a);
  endtask
endmodule

// file: test/tb.sv
// self-checking bench for the i2c slave and host-driven outputs
`timescale 1ns/1ps
module tb;
  localparam int GAP = 500;
  logic       clk_sys, reset, attnReq, noiseHigh, beeperWaveA, beeperWaveB, hostAttnLow, spaced;
  logic [6:0] slaveAddr;
  logic [2:0] devMode;
  logic [1:0] beeperCfg;
  logic [7:0] acks, mdl [8], got [8];
  int         err_count, comparisons, cyc;
  wire        sclIn, sdaLow, sdaOut_r, sdaOeN_r, attnOut_r, attnOeN_r;
  wire        hostOutA_r, hostOutB_r, beeperPinA_r, beeperPinB_r, bootDone_r;
  // open-drain lines with pull-ups
  wire        sdaIn  = !sdaLow && (sdaOeN_r || sdaOut_r);
  wire        attnIn = !hostAttnLow && (attnOeN_r || attnOut_r);
  wire [7:0]  outs   = {4'h0, beeperPinA_r, beeperPinB_r, hostOutB_r, hostOutA_r};
  tcgpo_i2c_slave #(.BOOT_NORM_CYC(2000), .BOOT_HIGH_CYC(4000), .GAP_CYC(GAP), .PULSE_CYC(300)) i_tcgpo_i2c_slave (.*);
  tcgpo_host_model i_tcgpo_host_model (.scl(sclIn), .sdaLow(sdaLow), .sda(sdaIn));
  // clock and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // write frame: register index then n bytes d, d+1, ...; acks counts acknowledges
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input int n, input logic [7:0] d);
    logic k;
    if (spaced) wc(GAP + 20);
    acks = 8'h00;
    i_tcgpo_host_model.start();
    for (int i = -2; i < n; i++) begin
      i_tcgpo_host_model.sendByte(i == -2 ? {a, 1'b0} : i == -1 ? r : d + 8'(i), k);
      acks = acks + k;
    end
    i_tcgpo_host_model.stop();
    wc(40);
  endtask
  task automatic rd(input int n);
    logic k;
    if (spaced) wc(GAP + 20);
    i_tcgpo_host_model.start();
    i_tcgpo_host_model.sendByte({slaveAddr, 1'b1}, k);
    acks = {7'h00, k};
    for (int i = 0; i < n; i++) i_tcgpo_host_model.getByte(i < n - 1, got[i]);
    i_tcgpo_host_model.stop();
    wc(2);
  endtask
  task automatic cmpRd(input int p, input int n);
    check(acks, 8'h01);
    for (int i = 0; i < n; i++) check(got[i], mdl[(p + i) % 8]);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    attnReq = 1'b0;
    noiseHigh = 1'b0;
    beeperWaveA = 1'b0;
    beeperWaveB = 1'b1;
    hostAttnLow = 1'b1;
    slaveAddr = 7'h37;
    devMode = 3'h0;
    beeperCfg = 2'h0;
    spaced = 1'b0;
    mdl = '{default: 8'h00};
    wc(10);
    reset = 1'b0;
    wc(50);
    check(outs, 8'h02);
    wr(7'h37, 8'h00, 1, 8'h0f);
    check(acks, 8'h00);
    for (int i = 0; i < 3000 && bootDone_r !== 1'b1; i++) wc(1);
    check({7'h00, bootDone_r}, 8'h01);
    done("boot");
    spaced = 1'b1;
    wr(7'h38, 8'h00, 1, 8'h0f);
    check(acks, 8'h00);
    check(outs, 8'h00);
    wr(7'h37, 8'h00, 1, 8'h09);
    check(acks, 8'h03);
    check(outs, 8'h09);
    beeperCfg = 2'h1;
    wc(3);
    check(outs, 8'h01);
    beeperCfg = 2'h2;
    wc(3);
    check(outs, 8'h05);
    beeperCfg = 2'h0;
    for (int m = 0; m < 5; m++) begin
      devMode = 3'(m);
      wr(7'h37, 8'h00, 1, 8'(m));
      if (m == 0 || m > 2) mdl[0] = 8'(m);
      check(outs, mdl[0]);
    end
    devMode = 3'h0;
    done("outputs");
    wr(7'h37, 8'h02, 3, 8'ha0);
    check(acks, 8'h05);
    for (int i = 0; i < 3; i++) mdl[2 + i] = 8'ha0 + 8'(i);
    wr(7'h37, 8'h02, 0, 8'h00);
    check(acks, 8'h02);
    rd(3);
    cmpRd(2, 3);
    mdl[1] = 8'h80;
    wr(7'h37, 8'h07, 0, 8'h00);
    rd(3);
    cmpRd(7, 3);
    done("access");
    wr(7'h37, 8'h07, 1, 8'h5a);
    spaced = 1'b0;
    rd(1);
    check(got[0], 8'h00);
    wr(7'h37, 8'h03, 1, 8'h11);
    wr(7'h37, 8'h03, 1, 8'h22);
    wr(7'h37, 8'h05, 1, 8'h44);
    spaced = 1'b1;
    mdl[7] = 8'h5a;
    mdl[3] = 8'h22;
    mdl[5] = 8'h44;
    wr(7'h37, 8'h03, 0, 8'h00);
    rd(5);
    cmpRd(3, 5);
    done("spacing");
    wr(7'h37, 8'h02, 32, 8'h40);
    check(acks, 8'h22);
    for (int i = 0; i < 32; i++) if ((i + 2) % 8 != 1) mdl[(i + 2) % 8] = 8'h40 + 8'(i);
    wr(7'h37, 8'h00, 0, 8'h00);
    rd(8);
    cmpRd(0, 8);
    check(outs, {4'h0, mdl[0][3:0]});
    done("burst");
    hostAttnLow = 1'b0;
    wr(7'h37, 8'h06, 1, 8'h77);
    check(acks, 8'h00);
    attnReq = 1'b1;
    wr(7'h37, 8'h06, 1, 8'h77);
    check(acks, 8'h03);
    attnReq = 1'b0;
    hostAttnLow = 1'b1;
    done("attention");
    noiseHigh = 1'b1;
    reset = 1'b1;
    wc(2);
    reset = 1'b0;
    wc(2500);
    check({7'h00, bootDone_r}, 8'h00);
    check(outs, 8'h00);
    wc(1600);
    check({7'h00, bootDone_r}, 8'h01);
    done("noise");
    stop_test();
  end
endmodule
